// ===== src/seto_mem.sv
// Single-port byte array with registered read data.
`timescale 1ns/100ps
module seto_mem
    import seto_pkg::*;
#(
    parameter int DEPTH = MEM_DEPTH
) (
    // System clock and reset
    input  wire logic  clk_sys,
    input  wire logic  nrst,
    // Memory port
    seto_mem_if.mem    port
);

    generate
        if (DEPTH != 2 ** ADDR_W) begin : g_bad_depth
            $error("DEPTH must cover every address");
        end
    endgenerate

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
    } seto_mem_st_t;

    logic [DATA_W-1:0] cells [DEPTH];
    seto_mem_st_t      s;
    seto_mem_st_t      n;

    // The array is not reset, so it keeps its contents across a reset pulse.
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            cells[i] = ERASED_BYTE;
        end
    end

    always_comb begin
        n = s;
        if (port.rdEn) begin
            n.rdata = cells[port.addr];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else if (port.en) begin
            s <= n;
        end
    end

    // A plain always lets the power-on fill and the write port share one array.
    always @(posedge clk_sys) begin
        if (port.en && port.wrEn) begin
            cells[port.addr] <= port.wdata;
        end
    end

    assign port.rdata = s.rdata;

endmodule : seto_mem

// ===== src/seto_mem_if.sv
// Port bundle between the command logic and its memory array.
`timescale 1ns/100ps
interface seto_mem_if;
    import seto_pkg::*;
    logic               en;
    logic               wrEn;
    logic               rdEn;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  wdata;
    logic [DATA_W-1:0]  rdata;

    modport ctrl (output en, output wrEn, output rdEn, output addr, output wdata, input rdata);
    modport mem  (input en, input wrEn, input rdEn, input addr, input wdata, output rdata);
endinterface : seto_mem_if

// ===== src/seto_pkg.sv
// Shared constants and types of the serial EEPROM target command logic.
// Notes on behaviour
// - A write selection is acknowledged, then exactly one low address byte is acknowledged.
// - Programming starts only on a stop right after a data byte acknowledge.
// - After programming the counter points just past the last modified byte.
// - While programming, the data line is released and all bus traffic ignored.
// - A byte write is selection, address, one acknowledged data byte, then stop.
// - Up to sixteen data bytes per cycle, all inside one page.
// - Bytes past the page end wrap to offset zero of the same page.
// - Every write data byte is acknowledged and the in-page offset advances.
// - A selection during programming gets no acknowledge; afterwards it is served.
// - Each completed read byte advances the address counter by one.
// - The device samples the ninth slot; without acknowledge it releases and idles.
// - Random read is an address-loading write, repeated start, then a read selection.
// - A read selection without address load returns the byte at the counter.
// - Sequential reads continue while acknowledged; no acknowledge plus stop ends them.
// - Past the top location the read counter wraps to zero.
// - Every memory byte holds all ones when delivered.
// - Selection is 1010, 0, two top address bits, direction; byte gives the rest.
// - Only a matching selection is acknowledged; otherwise silent until the next start or stop.
// - The data line is sampled on the rising serial clock edge.
package seto_pkg;

    // ----------------------------------------------------------------
    // Memory organisation
    // ----------------------------------------------------------------
    localparam int          ADDR_W        = 10;
    localparam int          MEM_DEPTH     = 1024;
    localparam int          DATA_W        = 8;
    localparam int          PAGE_BYTES    = 16;
    localparam int          PAGE_OFS_W    = 4;
    localparam logic [7:0]  ERASED_BYTE   = 8'hFF;

    // ----------------------------------------------------------------
    // Selection byte layout
    // ----------------------------------------------------------------
    localparam logic [4:0]  SEL_PATTERN   = 5'h14;
    localparam int          SEL_FIX_MSB   = 7;
    localparam int          SEL_FIX_LSB   = 3;
    localparam int          SEL_TOP_BIT   = 2;
    localparam int          SEL_SEC_BIT   = 1;
    localparam int          SEL_DIR_BIT   = 0;

    // ----------------------------------------------------------------
    // Bit slots and timing
    // ----------------------------------------------------------------
    localparam logic [3:0]  ACK_SLOT      = 4'h8;
    localparam logic [3:0]  LAST_BIT      = 4'h7;
    localparam int          CLK_SYS_HZ    = 40000000;
    localparam int          WRITE_CYCLE_TIME_MS = 5;
    localparam int          WRITE_CYCLE_CYCLES  = WRITE_CYCLE_TIME_MS * (CLK_SYS_HZ / 1000);

    typedef enum logic [2:0] {
        PH_IDLE   = 3'h0,
        PH_SELECT = 3'h1,
        PH_ADDR   = 3'h3,
        PH_WDATA  = 3'h2,
        PH_RDATA  = 3'h6,
        PH_IGNORE = 3'h7,
        PH_BUSY   = 3'h5
    } seto_state_t;

endpackage : seto_pkg

// ===== src/seto_target.sv
// Serial EEPROM target: bus decoding, page buffer, write cycle timer and reads.
`timescale 1ns/100ps
module seto_target
    import seto_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYCLE_CYCLES
) (
    // System clock, reset and enable
    input  wire logic  clk_sys,
    input  wire logic  nrst,
    input  wire logic  ce,
    // Serial link
    input  wire logic  sclClk,
    input  wire logic  sdaIn,
    output logic       sdaOut,
    output logic       sdaOeN,
    // Status
    output logic       writeBusy
);

    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    // The page buffer is drained one byte per cycle at the start of the
    // write cycle, so the cycle must be longer than one page.
    generate
        if (WRITE_CYCLES <= PAGE_BYTES) begin : g_bad_cycles
            $error("WRITE_CYCLES must exceed the page size");
        end
    endgenerate

    localparam int CW = $clog2(WRITE_CYCLES + 1);
    localparam logic [CW-1:0] BUSY_LAST = CW'(WRITE_CYCLES - 1);
    localparam logic [CW-1:0] PAGE_CNT  = CW'(PAGE_BYTES);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                         sclMeta;
        logic                         sclSync;
        logic                         sclPrev;
        logic                         sdaMeta;
        logic                         sdaSync;
        logic                         sdaPrev;
        logic                         bitMeta;
        logic                         bitSync;
        seto_state_t                  ph;
        logic [3:0]                   cnt;
        logic [7:0]                   shReg;
        logic [ADDR_W-1:0]            addr;
        logic [ADDR_W-1:0]            lastAddr;
        logic                         dataSeen;
        logic                         rnw;
        logic                         sdaLow;
        logic [PAGE_BYTES*DATA_W-1:0] pageBuf;
        logic [PAGE_BYTES-1:0]        pageMask;
        logic [CW-1:0]                busyCnt;
        logic                         memRd;
        logic                         memWr;
        logic [ADDR_W-1:0]            memAddr;
        logic [DATA_W-1:0]            memWdata;
    } seto_sys_t;

    typedef struct packed {
        logic bitQ;
    } seto_link_t;

    seto_sys_t   s;
    seto_sys_t   n;
    seto_link_t  ls;
    seto_link_t  ln;
    seto_mem_if  memBus ();

    logic        sclFall;
    logic        startSeen;
    logic        stopSeen;
    logic        rxBit;
    logic [7:0]  newByte;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic selMatch(input logic [7:0] b);
        return b[SEL_FIX_MSB:SEL_FIX_LSB] == SEL_PATTERN;
    endfunction : selMatch

    function automatic logic [ADDR_W-1:0] pageStep(input logic [ADDR_W-1:0] a);
        return {a[ADDR_W-1:PAGE_OFS_W], a[PAGE_OFS_W-1:0] + 4'h1};
    endfunction : pageStep

    // ----------------------------------------------------------------
    // Link domain
    // ----------------------------------------------------------------
    // Only the data bit is taken on the serial clock; it then stays
    // stable for the whole high phase and is carried over as a level.
    always_comb begin
        ln      = ls;
        ln.bitQ = sdaIn;
    end

    always_ff @(posedge sclClk or negedge nrst) begin
        if (!nrst) begin
            ls <= '0;
        end else begin
            ls <= ln;
        end
    end

    // ----------------------------------------------------------------
    // Bus events
    // ----------------------------------------------------------------
    assign sclFall   = ~s.sclSync & s.sclPrev;
    assign startSeen = s.sclSync & s.sclPrev & s.sdaPrev & ~s.sdaSync;
    assign stopSeen  = s.sclSync & s.sclPrev & ~s.sdaPrev & s.sdaSync;
    assign rxBit     = s.bitSync;
    assign newByte   = {s.shReg[6:0], rxBit};

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        n          = s;
        n.sclMeta  = sclClk;
        n.sclSync  = s.sclMeta;
        n.sclPrev  = s.sclSync;
        n.sdaMeta  = sdaIn;
        n.sdaSync  = s.sdaMeta;
        n.sdaPrev  = s.sdaSync;
        n.bitMeta  = ls.bitQ;
        n.bitSync  = s.bitMeta;
        n.memRd    = 1'b0;
        n.memWr    = 1'b0;

        if (s.ph == PH_BUSY) begin
            // Starts, stops and clocks are all ignored here.
            n.sdaLow = 1'b0;
            if (s.busyCnt < PAGE_CNT) begin
                if (s.pageMask[s.busyCnt[PAGE_OFS_W-1:0]]) begin
                    n.memWr    = 1'b1;
                    n.memAddr  = {s.lastAddr[ADDR_W-1:PAGE_OFS_W], s.busyCnt[PAGE_OFS_W-1:0]};
                    n.memWdata = s.pageBuf[s.busyCnt[PAGE_OFS_W-1:0]*DATA_W +: DATA_W];
                end
            end
            if (s.busyCnt == BUSY_LAST) begin
                n.ph       = PH_IDLE;
                n.addr     = s.lastAddr + 10'h001;
                n.pageMask = '0;
                n.cnt      = '0;
            end else begin
                n.busyCnt = s.busyCnt + 1'b1;
            end
        end else if (startSeen) begin
            // A repeated start drops any unprogrammed page data.
            n.ph       = PH_SELECT;
            // The clock fall that closes the start condition brings the count to zero.
            n.cnt      = 4'hF;
            n.sdaLow   = 1'b0;
            n.pageMask = '0;
            n.dataSeen = 1'b0;
        end else if (stopSeen) begin
            n.sdaLow = 1'b0;
            if (s.ph == PH_WDATA && s.cnt == 4'h0 && s.dataSeen) begin
                n.ph      = PH_BUSY;
                n.busyCnt = '0;
            end else begin
                n.ph       = PH_IDLE;
                n.pageMask = '0;
            end
        end else if (sclFall && s.ph != PH_IDLE && s.ph != PH_IGNORE) begin
            if (s.cnt == ACK_SLOT) begin
                n.cnt    = '0;
                n.sdaLow = 1'b0;
                case (s.ph)
                    PH_SELECT: begin
                        if (!s.sdaLow) begin
                            n.ph = PH_IGNORE;
                        end else if (s.rnw) begin
                            n.ph     = PH_RDATA;
                            n.shReg  = memBus.rdata;
                            n.sdaLow = ~memBus.rdata[7];
                        end else begin
                            n.ph = PH_ADDR;
                        end
                    end
                    PH_ADDR: begin
                        n.ph = PH_WDATA;
                    end
                    PH_RDATA: begin
                        if (rxBit) begin
                            n.ph = PH_IGNORE;
                        end else begin
                            n.shReg  = memBus.rdata;
                            n.sdaLow = ~memBus.rdata[7];
                        end
                    end
                    default: begin
                        n.ph = s.ph;
                    end
                endcase
            end else begin
                n.cnt = s.cnt + 4'h1;
                if (s.ph == PH_RDATA) begin
                    if (s.cnt == LAST_BIT) begin
                        // Release for the controller's answer and fetch ahead,
                        // so the next byte is ready at the end of the slot.
                        n.sdaLow  = 1'b0;
                        n.addr    = s.addr + 10'h001;
                        n.memRd   = 1'b1;
                        n.memAddr = s.addr + 10'h001;
                    end else begin
                        n.shReg  = {s.shReg[6:0], 1'b0};
                        n.sdaLow = ~s.shReg[6];
                    end
                end else begin
                    n.shReg = newByte;
                    if (s.cnt == LAST_BIT) begin
                        case (s.ph)
                            PH_SELECT: begin
                                if (selMatch(newByte)) begin
                                    n.sdaLow   = 1'b1;
                                    n.rnw      = newByte[SEL_DIR_BIT];
                                    n.dataSeen = 1'b0;
                                    if (newByte[SEL_DIR_BIT]) begin
                                        n.memRd   = 1'b1;
                                        n.memAddr = s.addr;
                                    end else begin
                                        n.addr[ADDR_W-1] = newByte[SEL_TOP_BIT];
                                        n.addr[ADDR_W-2] = newByte[SEL_SEC_BIT];
                                    end
                                end
                            end
                            PH_ADDR: begin
                                n.sdaLow    = 1'b1;
                                n.addr[7:0] = newByte;
                            end
                            PH_WDATA: begin
                                n.sdaLow                                         = 1'b1;
                                n.pageBuf[s.addr[PAGE_OFS_W-1:0]*DATA_W +: DATA_W] = newByte;
                                n.pageMask[s.addr[PAGE_OFS_W-1:0]]               = 1'b1;
                                n.lastAddr                                       = s.addr;
                                n.addr                                           = pageStep(s.addr);
                                n.dataSeen                                       = 1'b1;
                            end
                            default: begin
                                n.sdaLow = 1'b0;
                            end
                        endcase
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else if (ce) begin
            s <= n;
        end
    end

    // ----------------------------------------------------------------
    // Memory
    // ----------------------------------------------------------------
    assign memBus.en    = ce;
    assign memBus.wrEn  = s.memWr;
    assign memBus.rdEn  = s.memRd;
    assign memBus.addr  = s.memAddr;
    assign memBus.wdata = s.memWdata;

    seto_mem #(
        .DEPTH (MEM_DEPTH)
    ) u_mem (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .port    (memBus)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // The pin is open drain: only a low level is ever driven.
    assign sdaOut    = 1'b0;
    assign sdaOeN    = ~s.sdaLow;
    assign writeBusy = (s.ph == PH_BUSY);

endmodule : seto_target

// ===== verif/seto_ctl_model.sv
// Bus controller model that frames starts, stops and bytes on the serial link.
`timescale 1ns/100ps
module seto_ctl_model (
    // Timing base and resolved data line
    input  wire logic lclk,
    input  wire logic sdaLine,
    // Lines driven by the controller
    output logic      sclClk,
    output logic      ctlSda
);
    // The clock stands high between frames; every phase spans at least one base period.
    initial begin
        sclClk = 1'b1;
        ctlSda = 1'b1;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge lclk);
    endtask : hold

    task automatic startCond();
        hold(1);
        ctlSda = 1'b1;
        hold(1);
        sclClk = 1'b1;
        hold(2);
        ctlSda = 1'b0;
        hold(2);
        sclClk = 1'b0;
    endtask : startCond

    task automatic stopCond();
        hold(1);
        ctlSda = 1'b0;
        hold(1);
        sclClk = 1'b1;
        hold(2);
        ctlSda = 1'b1;
        hold(2);
    endtask : stopCond

    // Data moves a base period after the clock falls, so no edge looks like a start or stop.
    task automatic bitIo(input logic b, output logic s);
        hold(1);
        ctlSda = b;
        hold(1);
        sclClk = 1'b1;
        hold(1);
        s = sdaLine;
        hold(1);
        sclClk = 1'b0;
    endtask : bitIo

    task automatic wrByte(input logic [7:0] b, output logic nak);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitIo(b[i], s);
        end
        bitIo(1'b1, nak);
    endtask : wrByte

    task automatic rdByte(output logic [7:0] b, input logic nak);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitIo(1'b1, b[i]);
        end
        bitIo(nak, s);
    endtask : rdByte
endmodule : seto_ctl_model

// ===== verif/seto_target_sva.sv
// Concurrent checks on the serial EEPROM target ports.
`timescale 1ns/100ps
module seto_target_sva
    import seto_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYCLE_CYCLES
) (
    // System side
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    // Serial link and status
    input wire logic sclClk,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOeN,
    input wire logic writeBusy
);
    typedef struct packed {
        logic [3:0]  sinceStop;
        logic [31:0] busyCnt;
        logic        sdaPrev;
    } seto_chk_t;

    seto_chk_t state_q;
    seto_chk_t state_d;

    // The link lines are sampled raw, so a stop is dated to within one system cycle.
    always_comb begin
        state_d = state_q;
        state_d.sdaPrev = sdaIn;
        if (sclClk && sdaIn && !state_q.sdaPrev) begin
            state_d.sinceStop = 4'h0;
        end else if (state_q.sinceStop != 4'hF) begin
            state_d.sinceStop = state_q.sinceStop + 4'h1;
        end
        state_d.busyCnt = writeBusy ? state_q.busyCnt + 32'h1 : 32'h0;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q <= '{sinceStop: 4'hF, busyCnt: 32'h0, sdaPrev: 1'b1};
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence stopRecent;
        state_q.sinceStop <= 4'h8;
    endsequence
    sequence busyRun;
        writeBusy [*8];
    endsequence

    busyQuiet_a: assert property (writeBusy |-> sdaOeN)
        else $error("data line driven during the write cycle");
    busyLength_a: assert property ($fell(writeBusy) |-> state_q.busyCnt >= 32'(WRITE_CYCLES - 1)
        && state_q.busyCnt <= 32'(WRITE_CYCLES + 1)) else $error("write cycle length off");
    busyCause_a: assert property ($rose(writeBusy) |-> stopRecent)
        else $error("write cycle began without a stop");
    busyRun_a: assert property ($rose(writeBusy) |-> busyRun)
        else $error("write cycle ended at once");
    driveLow_a: assert property ($fell(sdaOeN) |-> !sclClk)
        else $error("data line pulled while clock high");
    holdHigh_a: assert property (sclClk && $past(sclClk) |-> $stable(sdaOeN))
        else $error("data drive changed while clock high");
    openDrain_a: assert property (sdaOut == 1'b0)
        else $error("data drive value not low");
    resetIdle_a: assert property ($rose(nrst) |-> sdaOeN && !writeBusy)
        else $error("target not idle after reset");
endmodule : seto_target_sva

bind seto_target seto_target_sva #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
    .sclClk(sclClk), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .writeBusy(writeBusy));

// ===== verif/seto_target_tb.sv
// Self-checking bench for the serial EEPROM target.
`timescale 1ns/100ps
module seto_target_tb
    import seto_pkg::*;
;
    localparam int TB_WRITE_CYCLES = 400;
    logic       clk_sys;
    logic       nrst;
    logic       ce;
    logic       lclk;
    logic       sclClk;
    logic       ctlSda;
    logic       sdaOut;
    logic       sdaOeN;
    logic       writeBusy;
    wire logic  sdaIn;
    int         err_count;
    int         check_count;

    assign sdaIn = ctlSda & (sdaOeN | sdaOut);

    initial clk_sys = 1'b0;
    always #12.5 clk_sys = ~clk_sys;
    initial begin
        lclk = 1'b0;
        #3.1;
        forever #62.5 lclk = ~lclk;
    end

    seto_target #(.WRITE_CYCLES(TB_WRITE_CYCLES)) dut_u (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
        .sclClk(sclClk), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .writeBusy(writeBusy));
    seto_ctl_model ctl_u (.lclk(lclk), .sdaLine(sdaIn), .sclClk(sclClk), .ctlSda(ctlSda));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic waitBusy(input logic lvl);
        int n;
        n = 0;
        while (writeBusy !== lvl && n < 2000) begin
            @(negedge clk_sys);
            n++;
        end
        check(writeBusy, lvl);
    endtask : waitBusy

    task automatic loadAddr(input logic [9:0] a);
        logic nak;
        ctl_u.startCond();
        ctl_u.wrByte({SEL_PATTERN, a[9:8], 1'b0}, nak);
        check(nak, 1'b0);
        ctl_u.wrByte(a[7:0], nak);
        check(nak, 1'b0);
    endtask : loadAddr

    // Random read, the safer way to reach a location.
    task automatic readAt(input logic [9:0] a, input logic [7:0] exp [$]);
        logic nak;
        logic [7:0] b;
        loadAddr(a);
        ctl_u.startCond();
        ctl_u.wrByte({SEL_PATTERN, a[9:8], 1'b1}, nak);
        check(nak, 1'b0);
        foreach (exp[i]) begin
            ctl_u.rdByte(b, i == exp.size() - 1);
            check(b, exp[i]);
        end
        check(sdaOeN, 1'b1);
        ctl_u.stopCond();
    endtask : readAt

    task automatic t_blank();
        logic nak;
        logic [7:0] b;
        ctl_u.startCond();
        ctl_u.wrByte({SEL_PATTERN, 2'h0, 1'b1}, nak);
        check(nak, 1'b0);
        ctl_u.rdByte(b, 1'b0);
        check(b, ERASED_BYTE);
        ctl_u.rdByte(b, 1'b1);
        check(b, ERASED_BYTE);
        ctl_u.stopCond();
        $display("t_blank done");
    endtask : t_blank

    task automatic t_badSel();
        logic nak;
        ctl_u.startCond();
        ctl_u.wrByte(8'hB0, nak);
        check(nak, 1'b1);
        ctl_u.wrByte(8'hA1, nak);
        check(nak, 1'b1);
        ctl_u.stopCond();
        $display("t_badSel done");
    endtask : t_badSel

    task automatic t_badStop();
        logic nak;
        loadAddr(10'h040);
        for (int i = 0; i < 4; i++) begin
            ctl_u.bitIo(1'b0, nak);
        end
        ctl_u.stopCond();
        repeat (40) @(negedge clk_sys);
        check(writeBusy, 1'b0);
        readAt(10'h040, '{ERASED_BYTE});
        $display("t_badStop done");
    endtask : t_badStop

    task automatic t_byteWrite();
        logic nak;
        loadAddr(10'h000);
        ctl_u.wrByte(8'h5A, nak);
        check(nak, 1'b0);
        ctl_u.stopCond();
        waitBusy(1'b1);
        waitBusy(1'b0);
        readAt(10'h3FF, '{ERASED_BYTE, 8'h5A});
        $display("t_byteWrite done");
    endtask : t_byteWrite

    task automatic t_pageWrite();
        logic nak;
        logic [7:0] b;
        int polls;
        logic [7:0] pg [$];
        for (int i = 0; i < PAGE_BYTES; i++) begin
            pg.push_back(ERASED_BYTE);
        end
        loadAddr(10'h025);
        for (int i = 0; i < 18; i++) begin
            ctl_u.wrByte(8'h10 + 8'(i), nak);
            check(nak, 1'b0);
            pg[(5 + i) % PAGE_BYTES] = 8'h10 + 8'(i);
        end
        ctl_u.stopCond();
        polls = 0;
        do begin
            ctl_u.startCond();
            ctl_u.wrByte({SEL_PATTERN, 2'h0, 1'b1}, nak);
            polls++;
        end while (nak === 1'b1 && polls < 20);
        check(polls > 1, 1'b1);
        check(nak, 1'b0);
        ctl_u.rdByte(b, 1'b1);
        check(b, pg[7]);
        ctl_u.stopCond();
        readAt(10'h020, pg);
        $display("t_pageWrite done");
    endtask : t_pageWrite

    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        err_count = 0;
        check_count = 0;
        repeat (12) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (8) @(negedge clk_sys);
        t_blank();
        t_badSel();
        t_badStop();
        t_byteWrite();
        t_pageWrite();
        tally_and_finish();
    end

    // The tests need about a third of a millisecond; three times that means a hang.
    initial begin
        #1000000;
        err_count++;
        $display("watchdog expired");
        tally_and_finish();
    end
endmodule : seto_target_tb
